// File: gbpm_pkg.sv
package gbpm_pkg;

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    GBPM_SLEEP  = 2'h0,
    GBPM_RTC    = 2'h1,
    GBPM_SEARCH = 2'h2,
    GBPM_TRACK  = 2'h3
  } gbpm_mode_t;

  // Controller phases: entry to sleep is staged
  typedef enum logic [1:0]
  {
    GBPM_RUN      = 2'h0,   // Steady in current mode
    GBPM_QUIESCE  = 2'h1,   // RF off, clocks stopping
    GBPM_GATESET  = 2'h2    // Supply gates moved to sleep levels
  } gbpm_phase_t;

  // ---------------------------------------------------------------
  // Clock-enable bundle
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic masterClkEn;    // Master clock running
    logic tickClkEn;      // Millisecond tick and peripheral clocks
    logic trackClkEn;     // Clocks used by tracking logic
    logic searchClkEn;    // Extra clocks used only while searching
  } gbpm_clk_t;

  // Supply and enable pin bundle
  typedef struct packed
  {
    logic coreSupplySwitchGate;   // High powers the switched core supply
    logic ioSupplySwitchGate;     // Low powers the switched I/O supply
    logic rfFrontendEnable;       // 1 enables the front end
    logic switchedRegionIoOn;     // I/O of switched region active
    logic porEnable;              // Power-on reset function armed
  } gbpm_pwr_t;

  // Pin levels
  localparam logic GBPM_CORE_GATE_SLEEP = 1'h0;
  localparam logic GBPM_CORE_GATE_ON    = 1'h1;
  localparam logic GBPM_IO_GATE_SLEEP   = 1'h1;
  localparam logic GBPM_IO_GATE_ON      = 1'h0;
  localparam logic GBPM_RF_DISABLE      = 1'h0;
  localparam logic GBPM_RF_ENABLE       = 1'h1;

  // Mode on leaving reset
  localparam gbpm_mode_t GBPM_RESET_MODE = GBPM_RTC;

endpackage

// File: gbpm_power_modes.sv
`timescale 1ns/100ps
// Function
// - Sleep removes switched power, I/O off
// - Sleep stops master and all clocks
// - Sleep: RF off, power-on reset disabled
// - Receive-line falling edge wakes into RTC
// - RTC: both supplies on, track and search clocks gated
// - RTC: RF off, only master and tick/peripheral clocks
// - Search: all clocks, RF on
// - Track: RF on, subset of clocks
// - Awake modes change only by host command; sleep exits on the receive line
// - Core gate low sleep, high otherwise
// - I/O gate high sleep, low otherwise
// - RF enable 0 off, 1 on
module gbpm_power_modes
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Host mode command, same clock domain
  input  wire logic                  hostModeValid,
  input  wire gbpm_pkg::gbpm_mode_t  hostMode,
  // UART receive pin, asynchronous
  input  wire logic                  uartRx,
  // Mode and power outputs
  output gbpm_pkg::gbpm_mode_t       modeState,
  output gbpm_pkg::gbpm_pwr_t        pwrCtl,
  output gbpm_pkg::gbpm_clk_t        clkCtl
);

  // -------------------------------------------------------------
  // Receive-line synchroniser
  // -------------------------------------------------------------
  logic rxMeta_r;    // First stage, read only by rxSync_r
  logic rxSync_r;    // Second stage
  logic rxPrev_r;    // Delayed copy for edge detect
  logic rxFall;      // Falling edge seen

  // Two flops before any logic reads the pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxMeta_r <= 1'h1;
      rxSync_r <= 1'h1;
      rxPrev_r <= 1'h1;
    end
    else
    begin
      rxMeta_r <= uartRx;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  // Idle-high line going low is the wake event
  assign rxFall = rxPrev_r && !rxSync_r;

  // -------------------------------------------------------------
  // Mode state machine
  // -------------------------------------------------------------
  gbpm_pkg::gbpm_mode_t  mode_r;     // Current mode
  gbpm_pkg::gbpm_mode_t  mode_nxt;
  gbpm_pkg::gbpm_phase_t phase_r;    // Sleep-entry staging
  gbpm_pkg::gbpm_phase_t phase_nxt;

  // Next mode and phase
  always_comb
  begin
    mode_nxt  = mode_r;
    phase_nxt = phase_r;
    unique case (phase_r)
      gbpm_pkg::GBPM_RUN:
      begin
        if (mode_r == gbpm_pkg::GBPM_SLEEP)
        begin
          // Only the receive line leaves sleep
          if (rxFall)
            mode_nxt = gbpm_pkg::GBPM_RTC;
        end
        else if (hostModeValid && hostMode != mode_r)
        begin
          // Host alone steers awake modes
          if (hostMode == gbpm_pkg::GBPM_SLEEP)
            phase_nxt = gbpm_pkg::GBPM_QUIESCE;
          else
            mode_nxt = hostMode;
        end
      end
      gbpm_pkg::GBPM_QUIESCE:
      begin
        // RF and clocks are already off; now move the gates
        phase_nxt = gbpm_pkg::GBPM_GATESET;
      end
      gbpm_pkg::GBPM_GATESET:
      begin
        mode_nxt  = gbpm_pkg::GBPM_SLEEP;
        phase_nxt = gbpm_pkg::GBPM_RUN;
      end
      default:
      begin
        // Unused phase code: fall back safely
        phase_nxt = gbpm_pkg::GBPM_RUN;
      end
    endcase
  end

  // Register mode and phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r  <= gbpm_pkg::GBPM_RESET_MODE;
      phase_r <= gbpm_pkg::GBPM_RUN;
    end
    else
    begin
      mode_r  <= mode_nxt;
      phase_r <= phase_nxt;
    end
  end

  // -------------------------------------------------------------
  // Output decode
  // -------------------------------------------------------------
  gbpm_pkg::gbpm_pwr_t pwr_r;     // Registered so no glitch reaches pins
  gbpm_pkg::gbpm_pwr_t pwr_nxt;
  gbpm_pkg::gbpm_clk_t clk_r;
  gbpm_pkg::gbpm_clk_t clk_nxt;
  logic                sleeping;  // Sleep or staging into it
  logic                gateSleep; // Gates at sleep levels

  // Decode from next state so outputs align with mode_r
  always_comb
  begin
    sleeping  = (mode_nxt == gbpm_pkg::GBPM_SLEEP) ||
                (phase_nxt != gbpm_pkg::GBPM_RUN);
    gateSleep = (mode_nxt == gbpm_pkg::GBPM_SLEEP) ||
                (phase_nxt == gbpm_pkg::GBPM_GATESET);
    // Every field set on every path: no undefined state
    pwr_nxt.rfFrontendEnable = gbpm_pkg::GBPM_RF_DISABLE;
    clk_nxt = '0;
    unique case (mode_nxt)
      gbpm_pkg::GBPM_SEARCH:
      begin
        pwr_nxt.rfFrontendEnable = gbpm_pkg::GBPM_RF_ENABLE;
        clk_nxt = '{masterClkEn: 1'h1, tickClkEn: 1'h1,
                    trackClkEn: 1'h1, searchClkEn: 1'h1};
      end
      gbpm_pkg::GBPM_TRACK:
      begin
        pwr_nxt.rfFrontendEnable = gbpm_pkg::GBPM_RF_ENABLE;
        clk_nxt = '{masterClkEn: 1'h1, tickClkEn: 1'h1,
                    trackClkEn: 1'h1, searchClkEn: 1'h0};
      end
      gbpm_pkg::GBPM_RTC:
      begin
        // Master, ticks and peripherals only, RF stays off
        clk_nxt = '{masterClkEn: 1'h1, tickClkEn: 1'h1,
                    trackClkEn: 1'h0, searchClkEn: 1'h0};
      end
      gbpm_pkg::GBPM_SLEEP:
      begin
        clk_nxt = '0;
      end
    endcase
    if (sleeping)
    begin
      // Staging: RF and every clock off first
      pwr_nxt.rfFrontendEnable = gbpm_pkg::GBPM_RF_DISABLE;
      clk_nxt = '0;
    end
    // Supply gates move only once quiesced
    pwr_nxt.coreSupplySwitchGate = gateSleep ? gbpm_pkg::GBPM_CORE_GATE_SLEEP
                                             : gbpm_pkg::GBPM_CORE_GATE_ON;
    pwr_nxt.ioSupplySwitchGate   = gateSleep ? gbpm_pkg::GBPM_IO_GATE_SLEEP
                                             : gbpm_pkg::GBPM_IO_GATE_ON;
    pwr_nxt.switchedRegionIoOn   = !gateSleep;
    pwr_nxt.porEnable            = !gateSleep;
  end

  // Register outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_r <= '{coreSupplySwitchGate: gbpm_pkg::GBPM_CORE_GATE_ON,
                 ioSupplySwitchGate:   gbpm_pkg::GBPM_IO_GATE_ON,
                 rfFrontendEnable:     gbpm_pkg::GBPM_RF_DISABLE,
                 switchedRegionIoOn:   1'h1,
                 porEnable:            1'h1};
      clk_r <= '{masterClkEn: 1'h1, tickClkEn: 1'h1,
                 trackClkEn: 1'h0, searchClkEn: 1'h0};
    end
    else
    begin
      pwr_r <= pwr_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign modeState = mode_r;
  assign pwrCtl    = pwr_r;
  assign clkCtl    = clk_r;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  AST_SLEEP_PWR: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SLEEP |-> !pwr_r.switchedRegionIoOn)
    else $error("Switched region I/O on in sleep");
  AST_SLEEP_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SLEEP |-> clk_r == '0)
    else $error("Clock running in sleep");
  AST_SLEEP_RF: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SLEEP |-> !pwr_r.rfFrontendEnable && !pwr_r.porEnable)
    else $error("RF or reset armed in sleep");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SLEEP && rxFall |=> mode_r == gbpm_pkg::GBPM_RTC)
    else $error("No wake on receive edge");
  AST_RTC: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_RTC && phase_r == gbpm_pkg::GBPM_RUN |->
    clk_r.tickClkEn && !clk_r.trackClkEn && !pwr_r.rfFrontendEnable
    && pwr_r.coreSupplySwitchGate)
    else $error("Wrong RTC outputs");
  AST_SEARCH: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SEARCH && phase_r == gbpm_pkg::GBPM_RUN |->
    clk_r.searchClkEn && pwr_r.rfFrontendEnable)
    else $error("Wrong search outputs");
  AST_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_TRACK && phase_r == gbpm_pkg::GBPM_RUN |->
    !clk_r.searchClkEn && clk_r.trackClkEn && pwr_r.rfFrontendEnable)
    else $error("Wrong track outputs");
  AST_HOST_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    $past(mode_r) != gbpm_pkg::GBPM_SLEEP && $past(phase_r) == gbpm_pkg::GBPM_RUN
    && !$past(hostModeValid) |-> $stable(mode_r))
    else $error("Mode changed without host");
  AST_GATES: assert property (@(posedge clk) disable iff (!rst_n)
    pwr_r.coreSupplySwitchGate != pwr_r.ioSupplySwitchGate)
    else $error("Supply gates not opposite");
  AST_ENTRY_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pwr_r.coreSupplySwitchGate) |-> $past(clk_r) == '0
    && !$past(pwr_r.rfFrontendEnable))
    else $error("Gates moved before quiesce");

  COV_WAKE:   cover property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SLEEP ##1 mode_r == gbpm_pkg::GBPM_RTC);
  COV_SLEEP:  cover property (@(posedge clk) disable iff (!rst_n)
    phase_r == gbpm_pkg::GBPM_QUIESCE ##2 mode_r == gbpm_pkg::GBPM_SLEEP);
  COV_SEARCH: cover property (@(posedge clk) disable iff (!rst_n)
    mode_r == gbpm_pkg::GBPM_SEARCH ##1 mode_r == gbpm_pkg::GBPM_TRACK);

endmodule

// File: gbpm_host_model.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------
// Host control software and receive line, seen from the block
// -----------------------------------------------------------------
module gbpm_host_model
(
  // Command strobe and requested mode
  output logic                 hostModeValid,
  output gbpm_pkg::gbpm_mode_t hostMode,
  // Receive line, idles high
  output logic                 uartRx
);
  // Idle host: no command, line high
  initial
  begin
    hostModeValid = 1'h0;
    hostMode      = gbpm_pkg::GBPM_RTC;
    uartRx        = 1'h1;
  end

  // Place or drop a command; caller holds it across the taking edge
  task automatic drive(input logic v, input gbpm_pkg::gbpm_mode_t m);
    hostModeValid = v;
    hostMode      = m;
  endtask

  // Falling edge on the line wakes a sleeping device
  task automatic setRx(input logic lvl);
    uartRx = lvl;
  endtask
endmodule

// File: gbpm_power_modes_tb_top.sv
`timescale 1ns/100ps
`define GBPM_CHK(act, exp) \
  begin \
    checkCount++; \
    if ((act) !== (exp)) \
    begin \
      failCount++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
  end
module gbpm_power_modes_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                 clk;            // 250 MHz clock
  logic                 rst_n;          // Async reset, active low
  logic                 hostModeValid;  // From host model
  gbpm_pkg::gbpm_mode_t hostMode;       // From host model
  logic                 uartRx;         // From host model
  gbpm_pkg::gbpm_mode_t modeState;      // Current mode
  gbpm_pkg::gbpm_pwr_t  pwrCtl;         // Supply and enable pins
  gbpm_pkg::gbpm_clk_t  clkCtl;         // Clock enables
  int                   failCount;      // Mismatches
  int                   checkCount;     // Comparisons
  int                   cycleCount;     // Hang guard

  gbpm_power_modes u_gbpm_power_modes
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .hostModeValid (hostModeValid),
    .hostMode      (hostMode),
    .uartRx        (uartRx),
    .modeState     (modeState),
    .pwrCtl        (pwrCtl),
    .clkCtl        (clkCtl)
  );

  gbpm_host_model u_gbpm_host_model
  (
    .hostModeValid (hostModeValid),
    .hostMode      (hostMode),
    .uartRx        (uartRx)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial clk = 1'h0;
  always #2 clk = ~clk;

  // Whole run is about fifty cycles; a stall ends it as a failure
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 1000)
    begin
      failCount++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (failCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected pins then clock enables for a settled mode
  function automatic logic [8:0] expOut(input gbpm_pkg::gbpm_mode_t m);
    case (m)
      gbpm_pkg::GBPM_SLEEP:  return {gbpm_pkg::GBPM_CORE_GATE_SLEEP, gbpm_pkg::GBPM_IO_GATE_SLEEP,
                                     gbpm_pkg::GBPM_RF_DISABLE, 2'h0, 4'h0};
      gbpm_pkg::GBPM_RTC:    return {gbpm_pkg::GBPM_CORE_GATE_ON, gbpm_pkg::GBPM_IO_GATE_ON,
                                     gbpm_pkg::GBPM_RF_DISABLE, 2'h3, 4'hC};
      gbpm_pkg::GBPM_SEARCH: return {gbpm_pkg::GBPM_CORE_GATE_ON, gbpm_pkg::GBPM_IO_GATE_ON,
                                     gbpm_pkg::GBPM_RF_ENABLE, 2'h3, 4'hF};
      default:               return {gbpm_pkg::GBPM_CORE_GATE_ON, gbpm_pkg::GBPM_IO_GATE_ON,
                                     gbpm_pkg::GBPM_RF_ENABLE, 2'h3, 4'hE};
    endcase
  endfunction

  // Mode and every output against the mode's settled levels
  task automatic chkMode(input gbpm_pkg::gbpm_mode_t m);
    `GBPM_CHK(modeState, m)
    `GBPM_CHK({pwrCtl, clkCtl}, expOut(m))
  endtask

  // Entered and left at one step past a rising edge
  task automatic cmd(input gbpm_pkg::gbpm_mode_t m, input logic last);
    u_gbpm_host_model.drive(1'h1, m);
    @(posedge clk);
    #1;
    if (last)
      u_gbpm_host_model.drive(1'h0, m);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Back-to-back moves among the awake modes
  task automatic awakeModes();
    cmd(gbpm_pkg::GBPM_SEARCH, 1'h0);
    chkMode(gbpm_pkg::GBPM_SEARCH);
    cmd(gbpm_pkg::GBPM_TRACK, 1'h0);
    chkMode(gbpm_pkg::GBPM_TRACK);
    cmd(gbpm_pkg::GBPM_RTC, 1'h0);
    chkMode(gbpm_pkg::GBPM_RTC);
    cmd(gbpm_pkg::GBPM_TRACK, 1'h1);
    chkMode(gbpm_pkg::GBPM_TRACK);
  endtask

  // Same-mode command and a line edge while awake change nothing
  task automatic ignored();
    cmd(gbpm_pkg::GBPM_TRACK, 1'h1);
    u_gbpm_host_model.setRx(1'h0);
    repeat (8) @(posedge clk);
    #1;
    u_gbpm_host_model.setRx(1'h1);
    chkMode(gbpm_pkg::GBPM_TRACK);
  endtask

  // Staged entry to sleep, then a refused command while asleep
  task automatic sleepEntry();
    cmd(gbpm_pkg::GBPM_SLEEP, 1'h1);
    `GBPM_CHK({pwrCtl.rfFrontendEnable, clkCtl}, 5'h00)
    `GBPM_CHK(pwrCtl.coreSupplySwitchGate, gbpm_pkg::GBPM_CORE_GATE_ON)
    @(posedge clk);
    #1;
    // Gates reach sleep levels one cycle before the mode reports sleep
    `GBPM_CHK({pwrCtl, clkCtl}, expOut(gbpm_pkg::GBPM_SLEEP))
    `GBPM_CHK(modeState, gbpm_pkg::GBPM_TRACK)
    @(posedge clk);
    #1;
    chkMode(gbpm_pkg::GBPM_SLEEP);
    cmd(gbpm_pkg::GBPM_SEARCH, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    chkMode(gbpm_pkg::GBPM_SLEEP);
  endtask

  // Falling receive line wakes into the clock-only mode
  task automatic wake();
    int n;
    n = 0;
    u_gbpm_host_model.setRx(1'h0);
    while (modeState !== gbpm_pkg::GBPM_RTC && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    u_gbpm_host_model.setRx(1'h1);
    `GBPM_CHK(n <= 4, 1'h1)
    chkMode(gbpm_pkg::GBPM_RTC);
  endtask

  // Reset in mid-run from search returns every output to reset levels
  task automatic midReset();
    cmd(gbpm_pkg::GBPM_SEARCH, 1'h1);
    chkMode(gbpm_pkg::GBPM_SEARCH);
    rst_n = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chkMode(gbpm_pkg::GBPM_RESET_MODE);
    rst_n = 1'h1;
    @(posedge clk);
    #1;
    chkMode(gbpm_pkg::GBPM_RESET_MODE);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    failCount  = 0;
    checkCount = 0;
    cycleCount = 0;
    rst_n      = 1'h0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'h1;
    chkMode(gbpm_pkg::GBPM_RESET_MODE);
    awakeModes();
    ignored();
    sleepEntry();
    wake();
    cmd(gbpm_pkg::GBPM_SLEEP, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    wake();
    midReset();
    finish_test();
  end
endmodule
